/* rtl/trigger_integration_test_regs.sv */
// Integration test registers of one trigger interface unit, word slave.
// Assumes the bus ready input is the combined ready of all slaves and
// that functional outputs come from logic on the same clock.
//
// Behaviour
// R1 - Bit zero enables test mode, reset clear.
// R2 - Reserved upper bits read as zero.
// R3 - Reads take three, writes four wait states.
// R4 - Test mode: input registers override internal inputs.
// R5 - Normal mode: input registers read live pins.
// R6 - Trigger fields eight bits, channel four.
// R7 - Test mode: output registers drive the outputs.
// R8 - Normal mode: output registers read functional values.
// R9 - Software uses test registers only in test.
// R10 - Master issues word transfers only.
// R11 - Protection bit one marks privileged access.
// R12 - Responses are only OKAY or ERROR.
// R13 - Own ready low stretches, high completes.
// R14 - Accept address only while bus ready high.
// R15 - Decode word address bits eleven to two.
// R16 - Thirty-two bit read and write data.
// R17 - Each unit has its own slave port.
// R18 - Test registers writable only in test mode.
// R19 - Unimplemented bits read zero, ignore writes.
// R20 - Reset clears the test enable.
`timescale 1ns/1ps
module trigger_integration_test_regs
    import test_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Register bus.
    input wire logic hsel,
    input wire logic [11:2] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire logic [31:0] hwdata,
    input wire logic hready_in,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // Pins into the unit.
    input wire logic [7:0] trigger_input,
    input wire logic [3:0] channel_input,
    input wire logic [7:0] trigger_output_ack,
    input wire logic [3:0] channel_output_ack,
    // Inputs as seen by the internal logic.
    output logic [7:0] core_trigger_input,
    output logic [3:0] core_channel_input,
    output logic [7:0] core_trigger_output_ack,
    output logic [3:0] core_channel_output_ack,
    // Values the functional logic drives.
    input wire logic [7:0] func_trigger_output,
    input wire logic [3:0] func_channel_output,
    input wire logic [7:0] func_trigger_input_ack,
    input wire logic [3:0] func_channel_input_ack,
    // Pins out of the unit.
    output logic [7:0] trigger_output,
    output logic [3:0] channel_output,
    output logic [7:0] trigger_input_ack,
    output logic [3:0] channel_input_ack,
    // Status.
    output logic integration_test_enable,
    output logic privileged_access
);

    // ****************************************************************
    // Bus slave state
    // ****************************************************************

    bus_state_e state_reg; // Phase of the current transfer.
    bus_state_e state_next;
    logic [2:0] cnt_reg; // Wait states still to insert.
    logic [2:0] cnt_next;
    xfer_s xfer_reg; // Context of the data phase.
    xfer_s xfer_next;
    logic hreadyout_reg; // Own ready output.
    logic hreadyout_next;
    logic [1:0] hresp_reg; // Response output.
    logic [1:0] hresp_next;
    logic [31:0] hrdata_reg; // Read data output.
    logic [31:0] hrdata_next;
    logic enable_reg; // Test enable.
    logic enable_next;
    logic priv_reg; // Privilege of the last accepted transfer.
    logic priv_next;
    logic wr_fire; // Write completes in this cycle.
    logic accept; // Address phase taken in this cycle.
    logic [3:0] req_slot; // Slot addressed by the address phase.
    logic req_bad; // Address phase to be refused.
    logic [7:0] src_arr [NUM_GROUPS]; // Sources of the groups.
    logic [7:0] value_arr [NUM_GROUPS]; // Selected values of the groups.

    // A transfer is taken only while the whole bus is ready.
    assign accept = hreadyout_reg && hready_in && hsel
                    && htrans[TRANS_ACTIVE_BIT]; // R14
    assign req_slot = decode_slot(haddr); // R15
    // Misses and non-word sizes get the two-cycle error.
    assign req_bad = (req_slot == SLOT_NONE)
                     || (hsize != HSIZE_WORD); // R10

    // Computes the next bus phase, outputs and register writes.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        xfer_next = xfer_reg;
        hreadyout_next = 1'b1;
        hresp_next = HRESP_OKAY;
        hrdata_next = 32'h0000_0000;
        enable_next = enable_reg;
        priv_next = priv_reg;
        wr_fire = 1'b0;
        case (state_reg)
            st_idle: begin
                // Capture the address phase and start stretching.
                if (accept) begin
                    xfer_next.write = hwrite;
                    xfer_next.slot = req_slot;
                    xfer_next.privileged = hprot[PROT_PRIV_BIT]; // R11
                    priv_next = hprot[PROT_PRIV_BIT]; // R11
                    hreadyout_next = 1'b0; // R13
                    if (req_bad) begin
                        state_next = st_error;
                        hresp_next = HRESP_ERROR; // R12
                    end else begin
                        state_next = st_wait;
                        cnt_next = hwrite ? WRITE_WAIT_STATES
                                          : READ_WAIT_STATES; // R3
                    end
                end
            end
            st_wait: begin
                if (cnt_reg > 3'h1) begin
                    // Further wait state.
                    cnt_next = cnt_reg - 3'h1;
                    hreadyout_next = 1'b0; // R13 R3
                end else begin
                    // Last wait state: complete in the next cycle.
                    state_next = st_idle;
                    if (xfer_reg.write) begin
                        wr_fire = 1'b1;
                        if (xfer_reg.slot == SLOT_CTRL) begin
                            enable_next = hwdata[ENABLE_BIT]; // R1
                        end
                    end else if (xfer_reg.slot == SLOT_CTRL) begin
                        hrdata_next = {31'h0, enable_reg}; // R1 R2
                    end else begin
                        // Group values are already masked to width.
                        hrdata_next = {24'h0,
                            value_arr[3'(xfer_reg.slot - 4'h1)]}; // R2 R16
                    end
                end
            end
            st_error: begin
                // Second cycle of the error response.
                state_next = st_idle;
                hresp_next = HRESP_ERROR; // R12
            end
            default: begin
                state_next = st_idle;
            end
        endcase
    end

    // Registers the bus phase; all state belongs to this one port.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= st_idle;
            cnt_reg <= 3'h0;
            xfer_reg <= '0;
            hreadyout_reg <= 1'b1;
            hresp_reg <= HRESP_OKAY;
            hrdata_reg <= 32'h0000_0000;
            enable_reg <= CTRL_RESET; // R20
            priv_reg <= 1'b0;
        end else begin
            state_reg <= state_next; // R17
            cnt_reg <= cnt_next;
            xfer_reg <= xfer_next;
            hreadyout_reg <= hreadyout_next;
            hresp_reg <= hresp_next;
            hrdata_reg <= hrdata_next;
            enable_reg <= enable_next;
            priv_reg <= priv_next;
        end
    end

    // ****************************************************************
    // Override groups
    // ****************************************************************

    // Pin groups first, then the functional outputs, in slot order.
    assign src_arr[0] = trigger_input;
    assign src_arr[1] = {4'h0, channel_input};
    assign src_arr[2] = trigger_output_ack;
    assign src_arr[3] = {4'h0, channel_output_ack};
    assign src_arr[4] = func_trigger_output;
    assign src_arr[5] = {4'h0, func_channel_output};
    assign src_arr[6] = func_trigger_input_ack;
    assign src_arr[7] = {4'h0, func_channel_input_ack};

    generate
        for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
            // Writes in normal mode are ignored.
            override_cell #(
                .SYNC(g < 4),
                .MASK(GROUP_MASK[g]) // R6
            ) u_cell (
                .clock(clock),
                .rstn(rstn),
                .enable(enable_reg),
                .wr_en(wr_fire && enable_reg
                       && (xfer_reg.slot == 4'(g + 1))), // R18 R4 R7
                .wr_data(hwdata[7:0]), // R16
                .src(src_arr[g]),
                .value(value_arr[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign core_trigger_input = value_arr[0];
    assign core_channel_input = value_arr[1][3:0];
    assign core_trigger_output_ack = value_arr[2];
    assign core_channel_output_ack = value_arr[3][3:0];
    assign trigger_output = value_arr[4];
    assign channel_output = value_arr[5][3:0];
    assign trigger_input_ack = value_arr[6];
    assign channel_input_ack = value_arr[7][3:0];
    assign integration_test_enable = enable_reg;
    assign privileged_access = priv_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_read_wait: assert property (accept && !req_bad && !hwrite |=> // R3
        !hreadyout [*3] ##1 hreadyout)
        else $error("read did not take three wait states");
    a_write_wait: assert property (accept && !req_bad && hwrite |=> // R3
        !hreadyout [*4] ##1 hreadyout)
        else $error("write did not take four wait states");
    a_size_error: assert property (accept && hsize != HSIZE_WORD |=> // R10
        (!hreadyout && hresp == HRESP_ERROR) ##1
        (hreadyout && hresp == HRESP_ERROR))
        else $error("non-word transfer not refused in two cycles");
    a_resp_legal: assert property (hresp[1] == 1'b0) // R12
        else $error("retry or split response driven");
    a_idle_hold: assert property (hreadyout && !accept |=> hreadyout) // R14
        else $error("ready dropped without an accepted transfer");
    a_ctrl_read: assert property (accept && !req_bad && !hwrite // R1
        && req_slot == SLOT_CTRL |-> ##4
        (hreadyout && hrdata == {31'h0, integration_test_enable}))
        else $error("control read returned the wrong value");
    a_reserved_zero: assert property (hrdata[31:8] == 24'h0) // R2
        else $error("reserved read data bits not zero");
    a_unimpl_zero: assert property (accept && !req_bad && !hwrite // R19
        && req_slot == 4'h2 |-> ##4 hrdata[31:4] == 28'h0)
        else $error("unimplemented channel bits not zero");
    a_test_drive: assert property (wr_fire && enable_reg // R7
        && xfer_reg.slot == 4'h5 |-> ##2
        trigger_output == $past(hwdata[7:0], 2))
        else $error("test write did not reach the trigger outputs");
    a_input_override: assert property (wr_fire && enable_reg // R4
        && xfer_reg.slot == 4'h1 |-> ##2
        core_trigger_input == $past(hwdata[7:0], 2))
        else $error("test write did not override trigger inputs");
    // Reset holds the mux registers, so the output path is one edge and
    // the synchronised pin path three edges behind the release.
    a_normal_out: assert property ($past(rstn) // R8
        && !$past(integration_test_enable) |->
        trigger_output == $past(func_trigger_output))
        else $error("normal mode outputs not from functional logic");
    a_normal_in: assert property ($past(rstn) && $past(rstn, 2) // R5
        && $past(rstn, 3) && !$past(integration_test_enable) |->
        core_trigger_input == $past(trigger_input, 3))
        else $error("normal mode inputs not from the pins");

    c_read: cover property (accept && !req_bad && !hwrite);
    c_write: cover property (accept && !req_bad && hwrite);
    c_error: cover property (accept && req_bad);
    c_override: cover property (wr_fire && enable_reg
        && xfer_reg.slot != SLOT_CTRL);

endmodule : trigger_integration_test_regs

/* rtl/test_regs_pkg.sv */
// Constants, types and decode helpers for the integration test registers.
// Assumes a word-only bus slave with register offsets in bits [11:0].
package test_regs_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************

    // Byte offset of the control register.
    localparam logic [11:0] CTRL_OFFSET = 12'h200;
    // Number of override groups behind the control register.
    localparam int NUM_GROUPS = 8;
    // Byte offsets of the groups, in slot order one to eight.
    localparam logic [11:0] GROUP_OFFSET [NUM_GROUPS] = '{
        12'h204, 12'h208, 12'h20c, 12'h210,
        12'h214, 12'h218, 12'h21c, 12'h220
    };
    // Implemented bits of each group; the rest read as zero.
    localparam logic [7:0] GROUP_MASK [NUM_GROUPS] = '{
        8'hff, 8'h0f, 8'hff, 8'h0f,
        8'hff, 8'h0f, 8'hff, 8'h0f
    };
    // Position of the test enable in the control register.
    localparam int unsigned ENABLE_BIT = 0;
    // Reset value of the test enable.
    localparam logic CTRL_RESET = 1'b0;
    // Reset value of every stored test value.
    localparam logic [7:0] TEST_VALUE_RESET = 8'h00;

    // ****************************************************************
    // Bus encodings and timing
    // ****************************************************************

    // Wait states inserted before a read or a write completes.
    localparam logic [2:0] READ_WAIT_STATES = 3'h3;
    localparam logic [2:0] WRITE_WAIT_STATES = 3'h4;
    // Transfer type bit that marks an active transfer.
    localparam int unsigned TRANS_ACTIVE_BIT = 1;
    // Only word transfers are legal.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Responses used by this slave.
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HRESP_ERROR = 2'h1;
    // Protection bit that marks a privileged access.
    localparam int unsigned PROT_PRIV_BIT = 1;
    // Slot codes for the control register and for a miss.
    localparam logic [3:0] SLOT_CTRL = 4'h0;
    localparam logic [3:0] SLOT_NONE = 4'hf;

    // ****************************************************************
    // Types
    // ****************************************************************

    // Bus phase of the slave.
    typedef enum logic [1:0] {
        st_idle,
        st_wait,
        st_error
    } bus_state_e;

    // Data phase context captured with the address phase.
    typedef struct packed {
        logic write;
        logic [3:0] slot;
        logic privileged;
    } xfer_s;

    // Maps a word address onto a slot code.
    function automatic logic [3:0] decode_slot(input logic [9:0] word_addr);
        logic [3:0] slot;
        slot = SLOT_NONE;
        if (word_addr == CTRL_OFFSET[11:2]) begin
            slot = SLOT_CTRL;
        end
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (word_addr == GROUP_OFFSET[g][11:2]) begin
                slot = 4'(g + 1);
            end
        end
        return slot;
    endfunction : decode_slot

endpackage : test_regs_pkg

/* rtl/override_cell.sv */
// One override group: a stored test value and the mux that picks it.
// Assumes enable and write strobe come from the same clock domain.
`timescale 1ns/1ps
module override_cell
    import test_regs_pkg::*;
#(
    parameter bit SYNC = 1'b0,
    parameter logic [7:0] MASK = 8'hff
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Control from the register slave.
    input wire logic enable,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Functional source and the selected value.
    input wire logic [7:0] src,
    output logic [7:0] value
);

    // ****************************************************************
    // Source capture
    // ****************************************************************

    logic [7:0] live; // Source as seen by the mux.

    generate
        if (SYNC) begin : g_sync
            logic [7:0] sync1_reg; // First stage, read only by the second.
            logic [7:0] sync2_reg; // Second stage, safe to use.
            // Two stages guard against a pin from another domain.
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    sync1_reg <= 8'h00;
                    sync2_reg <= 8'h00;
                end else begin
                    sync1_reg <= src;
                    sync2_reg <= sync1_reg;
                end
            end
            assign live = sync2_reg;
        end else begin : g_direct
            // Same-domain logic is used as it stands.
            assign live = src;
        end
    endgenerate

    // ****************************************************************
    // Test value and mux
    // ****************************************************************

    logic [7:0] test_reg; // Stored test value.
    logic [7:0] test_next;
    logic [7:0] value_reg; // Registered mux output.
    logic [7:0] value_next;

    // Unimplemented bits are dropped on write and on the mux.
    always_comb begin
        test_next = test_reg;
        if (wr_en) begin
            test_next = wr_data & MASK; // R19
        end
        value_next = (enable ? test_reg : live) & MASK; // R4 R5 R7 R8
    end

    // Registers the test value and the selected value.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            test_reg <= TEST_VALUE_RESET;
            value_reg <= TEST_VALUE_RESET;
        end else begin
            test_reg <= test_next;
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule : override_cell

/* sim/bus_master_model.sv */
// Word bus master that runs one transfer per request pulse.
// Assumes a single slave, so the combined ready is the slave's own ready.
`timescale 1ns/1ps
module bus_master_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Request from the bench.
    input wire logic go,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [2:0] size,
    input wire logic [3:0] prot,
    // Bus towards the slave.
    input wire logic hready,
    input wire logic [1:0] hresp,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [11:2] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [3:0] hprot,
    output logic [31:0] hwdata,
    // Result of the last transfer.
    output logic done,
    output logic [31:0] rd_data,
    output logic [1:0] rd_resp,
    output logic [3:0] waits
);
    // Phase: 0 idle, 1 address, 2 data.
    logic [1:0] phase;

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************

    // Released lines other than hsel and htrans show the inverse of their last value, not a hold.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase <= 2'h0;
            hsel <= 1'b0;
            htrans <= 2'h0;
            haddr <= 10'h0;
            hwrite <= 1'b0;
            hsize <= 3'h2;
            hprot <= 4'h0;
            hwdata <= 32'h0;
            done <= 1'b0;
            rd_data <= 32'h0;
            rd_resp <= 2'h0;
            waits <= 4'h0;
        end else begin
            done <= 1'b0;
            if (phase == 2'h0 && go) begin
                // Word size unless a refusal is commanded.
                hsel <= 1'b1;
                htrans <= 2'h2;
                haddr <= addr[11:2];
                hwrite <= wr;
                hsize <= size;
                hprot <= prot;
                waits <= 4'h0;
                phase <= 2'h1;
            end else if (phase == 2'h1 && hready) begin
                // Address taken only with ready high.
                hsel <= 1'b0;
                htrans <= 2'h0;
                haddr <= ~haddr;
                hwrite <= ~hwrite;
                hsize <= ~hsize;
                hprot <= ~hprot;
                hwdata <= wdata;
                phase <= 2'h2;
            end else if (phase == 2'h2) begin
                if (hready) begin
                    rd_data <= hrdata;
                    rd_resp <= hresp;
                    done <= 1'b1;
                    hwdata <= ~hwdata;
                    phase <= 2'h0;
                end else begin
                    waits <= waits + 4'h1;
                end
            end
        end
    end
endmodule : bus_master_model

/* sim/trigger_integration_test_regs_test.sv */
// Self-checking bench for the integration test registers.
// Assumes the master model in bus_master_model.sv and the package.
`timescale 1ns/1ps
`define CHECK(name, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %s expected %h seen %h", name, exp, got); end end
module trigger_integration_test_regs_test;
    import test_regs_pkg::*;
    // Bench controls and bus wires.
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic go = 1'b0, wr = 1'b0, hsel, hwrite, hreadyout, done, priv;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, hwdata, hrdata, rd_data;
    logic [2:0] size = 3'h2, hsize;
    logic [3:0] prot = 4'h0, hprot, waits;
    logic [11:2] haddr;
    logic [1:0] htrans, hresp, rd_resp;
    logic enable;
    // Pin and functional sources, and what each group shows.
    logic [7:0] src [8];
    wire logic [7:0] obs [8];
    int n_fail = 0;
    int samples_checked = 0;

    always #2 clock = ~clock;

    bus_master_model master (.clock(clock), .rstn(rstn), .go(go), .wr(wr),
        .addr(addr), .wdata(wdata), .size(size), .prot(prot),
        .hready(hreadyout), .hresp(hresp), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hprot(hprot), .hwdata(hwdata), .done(done), .rd_data(rd_data),
        .rd_resp(rd_resp), .waits(waits));

    trigger_integration_test_regs uut (.clock(clock), .rstn(rstn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
        .hready_in(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .trigger_input(src[0]),
        .channel_input(src[1][3:0]), .trigger_output_ack(src[2]),
        .channel_output_ack(src[3][3:0]), .core_trigger_input(obs[0]),
        .core_channel_input(obs[1][3:0]),
        .core_trigger_output_ack(obs[2]),
        .core_channel_output_ack(obs[3][3:0]),
        .func_trigger_output(src[4]), .func_channel_output(src[5][3:0]),
        .func_trigger_input_ack(src[6]),
        .func_channel_input_ack(src[7][3:0]), .trigger_output(obs[4]),
        .channel_output(obs[5][3:0]), .trigger_input_ack(obs[6]),
        .channel_input_ack(obs[7][3:0]), .integration_test_enable(enable),
        .privileged_access(priv));

    // Four-bit groups leave their upper observed bits at zero.
    assign obs[1][7:4] = 4'h0;
    assign obs[3][7:4] = 4'h0;
    assign obs[5][7:4] = 4'h0;
    assign obs[7][7:4] = 4'h0;

    // ****************************************************************
    // Tasks
    // ****************************************************************

    // Prints the counts and the verdict, then stops the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Runs one transfer and checks its response and wait count.
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [2:0] s, input logic [3:0] p,
            input logic [1:0] exp_resp, input logic [3:0] exp_waits);
        int i;
        @(posedge clock);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        size <= s;
        prot <= p;
        @(posedge clock);
        go <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            #1;
            if (done === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            print_verdict();
        end
        `CHECK("response", exp_resp, rd_resp)
        `CHECK("wait states", exp_waits, waits)
    endtask : xfer

    // ****************************************************************
    // Scenarios
    // ****************************************************************

    initial begin
        for (int g = 0; g < 8; g++) src[g] <= 8'h3c ^ 8'(g * 17);
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        // Control reads clear after reset.
        xfer(0, CTRL_OFFSET, 0, HSIZE_WORD, 0, HRESP_OKAY, 4'h3);
        `CHECK("ctrl reset", {31'h0, CTRL_RESET}, rd_data)
        `CHECK("enable reset", 1'b0, enable)
        // Unmapped word and a byte size are refused.
        xfer(0, 12'h1fc, 0, HSIZE_WORD, 0, HRESP_ERROR, 4'h1);
        xfer(0, CTRL_OFFSET, 0, 3'h0, 0, HRESP_ERROR, 4'h1);
        // Normal mode: writes ignored, reads show live values.
        for (int g = 0; g < 8; g++) begin
            xfer(1, GROUP_OFFSET[g], 32'hffffffff, HSIZE_WORD, 0,
                HRESP_OKAY, 4'h4);
            xfer(0, GROUP_OFFSET[g], 0, HSIZE_WORD, 0, HRESP_OKAY, 4'h3);
            `CHECK("live read", {24'h0, src[g] & GROUP_MASK[g]}, rd_data)
        end
        // Enter test mode with every bit set; only bit zero sticks.
        xfer(1, CTRL_OFFSET, 32'hffffffff, HSIZE_WORD, 4'h2, HRESP_OKAY,
            4'h4);
        `CHECK("privileged", 1'b1, priv)
        `CHECK("enable set", 1'b1, enable)
        xfer(0, CTRL_OFFSET, 0, HSIZE_WORD, 0, HRESP_OKAY, 4'h3);
        `CHECK("ctrl read", 32'h1, rd_data)
        // Test mode: each group still holds its reset value, as the
        // normal mode writes were dropped, then takes the written value.
        for (int g = 0; g < 8; g++) begin
            xfer(0, GROUP_OFFSET[g], 0, HSIZE_WORD, 0, HRESP_OKAY, 4'h3);
            `CHECK("ignored", {24'h0, TEST_VALUE_RESET & GROUP_MASK[g]},
                rd_data)
            xfer(1, GROUP_OFFSET[g], {24'hffffff, ~src[g]}, HSIZE_WORD, 0,
                HRESP_OKAY, 4'h4);
            xfer(0, GROUP_OFFSET[g], 0, HSIZE_WORD, 0, HRESP_OKAY, 4'h3);
            `CHECK("test read", {24'h0, ~src[g] & GROUP_MASK[g]}, rd_data)
            `CHECK("override", ~src[g] & GROUP_MASK[g], obs[g])
        end
        `CHECK("user access", 1'b0, priv)
        // Leaving test mode hands the signals back to their sources.
        xfer(1, CTRL_OFFSET, 0, HSIZE_WORD, 0, HRESP_OKAY, 4'h4);
        repeat (4) @(posedge clock);
        #1;
        for (int g = 0; g < 8; g++) begin
            `CHECK("released", src[g] & GROUP_MASK[g], obs[g])
        end
        print_verdict();
    end
endmodule : trigger_integration_test_regs_test
